/* hw/watchdog_timer_control.sv */
/*
  Watchdog timer control: counts rising edges of a free-running watchdog oscillator
  up to a selectable time-out and then raises an interrupt, a system reset
  request, or an interrupt followed by a reset. Software reaches the control
  register over AXI4-Lite. Assumes the oscillator pin is asynchronous to mclk
  and the safety level is a static configuration input on the mclk domain.

*/
`timescale 1ns/1ps

module watchdog_timer_control #(
  parameter int TIMEOUT_BASE = wdt_pkg::TIMEOUT_BASE_DEF
) (
  input wire logic mclk, // system clock, 40 MHz
  input wire logic nrst, // synchronous reset, active low
  input wire wdt_pkg::axil_req_t busReq, // AXI4-Lite master to slave
  output wdt_pkg::axil_rsp_t busRsp, // AXI4-Lite slave to master
  input wire logic wdtOscPin, // watchdog oscillator, asynchronous
  input wire logic [1:0] safetyLevel, // 0 none, 1 level 1, 2 level 2
  output logic irq, // level, unmasked status set
  output logic sysResetReq, // one-cycle system reset request
  output logic wdtRunning // timer counting
);
  import wdt_pkg::*;

  state_t s_q;
  state_t s_d;
  logic oscTick;
  logic running;
  logic timeout;
  logic ctrlWr;
  logic doWrite;
  logic doRead;
  logic [CNT_W-1:0] limit;
  logic [3:0] wrSel;
  logic [7:0] rdAddr;
  logic [1:0] stSet;

  // ------------------------------------------------------------------
  // bus handshakes and outputs
  // ------------------------------------------------------------------

  // ready while the holding slot is free and no response is pending
  assign busRsp.awready = !s_q.awHeld && !s_q.bvalid;
  assign busRsp.wready = !s_q.wHeld && !s_q.bvalid;
  assign busRsp.bvalid = s_q.bvalid;
  assign busRsp.bresp = s_q.bresp;
  assign busRsp.arready = !s_q.rvalid;
  assign busRsp.rvalid = s_q.rvalid;
  assign busRsp.rdata = s_q.rdata;
  assign busRsp.rresp = s_q.rresp;
  assign irq = s_q.irq;
  assign sysResetReq = s_q.rstPulse;
  assign wdtRunning = s_q.en || s_q.irqEn;

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------

  // time-out length for the held period code
  assign limit = CNT_W'(TIMEOUT_BASE) << s_q.sel;

  always_comb begin
    s_d = s_q;
    s_d.rstPulse = 1'b0;
    stSet = 2'h0;
    wrSel = 4'h0;
    rdAddr = busReq.araddr[ADDR_W-1:0];

    // oscillator pin: three stages, a rising edge counts once stages 2 and 3 agree
    s_d.oscSync = {s_q.oscSync[1:0], wdtOscPin};
    if (s_q.oscSync[1] == s_q.oscSync[2]) begin
      s_d.oscLvl = s_q.oscSync[2];
    end
    oscTick = (s_q.oscSync[1] == s_q.oscSync[2]) && s_q.oscSync[2] &&
      !s_q.oscLvl;

    // time-out counter; stopped when both action bits are clear
    running = s_q.en || s_q.irqEn;
    timeout = 1'b0;
    if (!running) begin
      s_d.cnt = '0;
    end else if (oscTick) begin
      if (s_q.cnt == limit - CNT_W'(1)) begin
        s_d.cnt = '0;
        timeout = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + CNT_W'(1);
      end
    end

    // unlock lifetime countdown
    if (s_q.unlockCnt != 3'h0) begin
      s_d.unlockCnt = s_q.unlockCnt - 3'h1;
      if (s_q.unlockCnt == 3'h1) begin
        s_d.unlock = 1'b0;
      end
    end

    // write address and data are taken in either order
    if (busReq.awvalid && busRsp.awready) begin
      s_d.awHeld = 1'b1;
      s_d.awAddr = busReq.awaddr[ADDR_W-1:0];
    end
    if (busReq.wvalid && busRsp.wready) begin
      s_d.wHeld = 1'b1;
      s_d.wData = busReq.wdata;
      s_d.wStrb = busReq.wstrb;
    end
    if (s_q.bvalid && busReq.bready) begin
      s_d.bvalid = 1'b0;
    end

    // perform the write once both halves are held
    doWrite = s_q.awHeld && s_q.wHeld && !s_q.bvalid;
    ctrlWr = doWrite && (s_q.awAddr == OFS_CTRL) && s_q.wStrb[0];
    if (doWrite) begin
      s_d.awHeld = 1'b0;
      s_d.wHeld = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      case (s_q.awAddr)
        OFS_CTRL: begin
          if (s_q.wStrb[0]) begin
            s_d.irqEn = s_q.wData[CTRL_IRQEN];
            // enabling is free, disabling needs the unlock
            if (s_q.wData[CTRL_EN]) begin
              s_d.en = 1'b1;
            end else if (s_q.unlock) begin
              s_d.en = 1'b0;
            end
            // period code, reserved codes clamp to the top valid code
            wrSel = {s_q.wData[CTRL_SEL_HI],
              s_q.wData[CTRL_SEL_LO+2:CTRL_SEL_LO]};
            if (wrSel > SEL_MAX) begin
              wrSel = SEL_MAX;
            end
            if (s_q.unlock && (wrSel != s_q.sel)) begin
              s_d.sel = wrSel;
              s_d.cnt = '0;
            end
            if (s_q.wData[CTRL_UNLOCK]) begin
              s_d.unlock = 1'b1;
              s_d.unlockCnt = UNLOCK_CYCLES;
            end
          end
        end
        OFS_STATUS: begin
        end
        OFS_MASK: begin
          if (s_q.wStrb[0]) begin
            s_d.mask = s_q.wData[1:0];
          end
        end
        OFS_RSTFLAG: begin
          if (s_q.wStrb[0] && !s_q.wData[0]) begin
            s_d.rstFlag = 1'b0;
          end
        end
        OFS_KICK: begin
          s_d.cnt = '0;
        end
        default: begin
          s_d.bresp = RESP_SLVERR;
        end
      endcase
    end

    // read channel: one read at a time, answer in the next cycle
    if (s_q.rvalid && busReq.rready) begin
      s_d.rvalid = 1'b0;
    end
    doRead = busReq.arvalid && busRsp.arready;
    if (doRead) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = 32'h0;
      case (rdAddr)
        OFS_CTRL: begin
          s_d.rdata[CTRL_SEL_LO+2:CTRL_SEL_LO] = s_q.sel[2:0];
          s_d.rdata[CTRL_EN] = s_q.en;
          s_d.rdata[CTRL_UNLOCK] = s_q.unlock;
          s_d.rdata[CTRL_SEL_HI] = s_q.sel[3];
          s_d.rdata[CTRL_IRQEN] = s_q.irqEn;
        end
        OFS_STATUS: begin
          s_d.rdata[1:0] = s_q.status;
          s_d.status = 2'h0; // read clears; new events below win
        end
        OFS_MASK: begin
          s_d.rdata[1:0] = s_q.mask;
        end
        OFS_RSTFLAG: begin
          s_d.rdata[0] = s_q.rstFlag;
        end
        OFS_KICK: begin
        end
        default: begin
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end

    // time-out action chosen from the pair held before this cycle
    if (timeout) begin
      if (s_q.irqEn) begin
        stSet[ST_TMO_IRQ] = 1'b1;
        if (s_q.en) begin
          s_d.irqEn = 1'b0;
        end
      end else if (s_q.en) begin
        s_d.rstPulse = 1'b1;
        s_d.rstFlag = 1'b1;
        stSet[ST_TMO_RST] = 1'b1;
      end
    end

    // safety overrides keep the watchdog enabled
    if (safetyLevel == SAFETY_L2) begin
      s_d.en = 1'b1;
    end
    if ((safetyLevel == SAFETY_L1) && s_d.rstFlag) begin
      s_d.en = 1'b1;
    end

    // sticky status, set wins over the read clear
    s_d.status = s_d.status | stSet;
    s_d.irq = |(s_d.status & s_d.mask);
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------

  // single register for the whole state
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  a_stop_quiet: assert property (
    (!s_q.en && !s_q.irqEn) |=> (s_q.cnt == '0) && !sysResetReq
  ) else $error("stopped watchdog counted or reset");

  a_irq_then_reset: assert property (
    (timeout && s_q.en && s_q.irqEn) |=>
      !s_q.irqEn && s_q.status[ST_TMO_IRQ] && !sysResetReq
  ) else $error("combined mode interrupt wrong");

  a_reset_on_tmo: assert property (
    (timeout && s_q.en && !s_q.irqEn) |=> sysResetReq ##1 !sysResetReq
  ) else $error("reset pulse missing or long");

  a_enable_locked: assert property (
    (s_q.en && !s_q.unlock) |=> s_q.en
  ) else $error("enable cleared without unlock");

  a_unlock_expire: assert property (
    ($rose(s_q.unlock) && !ctrlWr) |-> s_q.unlock[*4]
  ) else $error("unlock cleared early");

  a_unlock_end: assert property (
    (s_q.unlockCnt == 3'h1 && !ctrlWr) |=> !s_q.unlock
  ) else $error("unlock not cleared after four cycles");

  a_period_locked: assert property (
    !s_q.unlock |=> s_q.sel == $past(s_q.sel)
  ) else $error("period changed while locked");

  a_enable_set: assert property (
    (ctrlWr && s_q.wData[CTRL_EN]) |=> s_q.en
  ) else $error("enable write ignored");

  a_level2_hold: assert property (
    (safetyLevel == SAFETY_L2) |=> s_q.en
  ) else $error("watchdog disabled in safety level 2");

  a_level1_hold: assert property (
    (safetyLevel == SAFETY_L1 && s_q.rstFlag) |=> s_q.en
  ) else $error("enable clear while reset flag set");

  a_count_bound: assert property (
    s_q.cnt < limit
  ) else $error("count passed the time-out length");

  a_code_valid: assert property (
    s_q.sel <= SEL_MAX
  ) else $error("reserved period code held");

  a_restart_sel: assert property (
    (s_q.sel != $past(s_q.sel)) |-> (s_q.cnt == '0)
  ) else $error("count not restarted on period change");

  a_irq_mode_keep: assert property (
    (timeout && s_q.irqEn && !s_q.en && !ctrlWr) |=> s_q.irqEn
  ) else $error("interrupt-only mode lost irq-enable");

  a_reserved_clamp: assert property (
    (ctrlWr && s_q.unlock && s_q.wData[CTRL_SEL_HI] &&
      (s_q.wData[CTRL_SEL_LO+2:CTRL_SEL_LO] > 3'h1)) |=>
      (s_q.sel == SEL_MAX)
  ) else $error("reserved period code not clamped");

  a_kick_restart: assert property (
    (doWrite && s_q.awAddr == OFS_KICK) |=> (s_q.cnt == '0)
  ) else $error("kick did not restart the count");

  a_flag_on_reset: assert property (
    sysResetReq |-> s_q.rstFlag
  ) else $error("reset time-out left the flag clear");

  a_status_sticky: assert property (
    (s_q.status[ST_TMO_IRQ] && !(doRead && rdAddr == OFS_STATUS)) |=>
      s_q.status[ST_TMO_IRQ]
  ) else $error("interrupt status lost without a read");

endmodule

/* hw/wdt_pkg.sv */
/*
  Shared constants and types for the watchdog timer control block: register
  offsets, field positions, reset values, counts and the bus carrier structs.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package wdt_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00; // watchdog_control
  localparam logic [7:0] OFS_STATUS = 8'h04; // sticky events, read clears
  localparam logic [7:0] OFS_MASK = 8'h08; // interrupt mask
  localparam logic [7:0] OFS_RSTFLAG = 8'h0C; // watchdog_reset_flag
  localparam logic [7:0] OFS_KICK = 8'h10; // any write restarts the count

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int CTRL_SEL_LO = 0; // timeout_period_select[2:0] at 2:0
  localparam int CTRL_EN = 3; // watchdog_enable
  localparam int CTRL_UNLOCK = 4; // change_unlock
  localparam int CTRL_SEL_HI = 5; // timeout_period_select[3]
  localparam int CTRL_IRQEN = 6; // timeout_irq_enable
  localparam int ST_TMO_IRQ = 0; // time-out raised an interrupt
  localparam int ST_TMO_RST = 1; // time-out raised a system reset

  // ------------------------------------------------------------------
  // values and counts
  // ------------------------------------------------------------------
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4; // unlock lifetime, mclk
  localparam logic [3:0] SEL_MAX = 4'h9; // highest valid period code
  localparam int TIMEOUT_BASE_DEF = 2048; // osc cycles at code 0
  localparam int CNT_W = 21; // holds 2048 << 9
  localparam logic [1:0] SAFETY_L1 = 2'h1;
  localparam logic [1:0] SAFETY_L2 = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------------
  // bus carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  // ------------------------------------------------------------------
  // complete block state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] oscSync;
    logic oscLvl;
    logic [CNT_W-1:0] cnt;
    logic en;
    logic irqEn;
    logic unlock;
    logic [2:0] unlockCnt;
    logic [3:0] sel;
    logic rstFlag;
    logic [1:0] status;
    logic [1:0] mask;
    logic irq;
    logic rstPulse;
    logic awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  localparam state_t STATE_RST = '0; // everything idle, watchdog stopped

endpackage

/* tb/watchdog_timer_control_tb.sv */
/*
  Self-checking bench for watchdog_timer_control: register traffic over
  AXI4-Lite, a free-running oscillator and the safety level input.
  Assumes wdt_pkg is compiled first; a short TIMEOUT_BASE keeps runs brief.
*/
`timescale 1ns/1ps

module watchdog_timer_control_tb;
  import wdt_pkg::*;
  localparam int TB = 2; // shortened base count of oscillator edges
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  axil_req_t busReq = '{bready: 1'b1, rready: 1'b1, default: '0};
  axil_rsp_t busRsp;
  logic wdtOscPin = 1'b0;
  logic [1:0] safetyLevel = SAFETY_L1;
  logic irq;
  logic sysResetReq;
  logic wdtRunning;
  logic [2:0] oscDiv = 3'h0;
  int failCount = 0;
  int totalChecks = 0;
  int cyc = 0;
  int rstPulses = 0;
  logic [31:0] rv;
  logic [1:0] rs;

  // ------------------------------------------------------------------
  // clock, oscillator and hang guard
  // ------------------------------------------------------------------
  always #12.5 mclk = ~mclk;

  // one oscillator rising edge every 8 mclk cycles
  always @(posedge mclk) begin
    oscDiv <= oscDiv + 3'h1;
    wdtOscPin <= oscDiv[2];
    cyc <= cyc + 1;
    if (sysResetReq === 1'b1) begin
      rstPulses <= rstPulses + 1;
    end
    if (cyc == 20000) begin
      failCount++;
      summarize();
    end
  end

  watchdog_timer_control #(.TIMEOUT_BASE(TB)) u_dut (
    .mclk(mclk), .nrst(nrst), .busReq(busReq), .busRsp(busRsp),
    .wdtOscPin(wdtOscPin), .safetyLevel(safetyLevel), .irq(irq),
    .sysResetReq(sysResetReq), .wdtRunning(wdtRunning)
  );

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      failCount++;
    end
  endtask

  // write one word; handshakes judged on values settled before the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axil_rsp_t s;
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    busReq.awvalid <= 1'b1;
    busReq.awaddr <= {24'h0, a};
    busReq.wvalid <= 1'b1;
    busReq.wdata <= d;
    busReq.wstrb <= 4'hF;
    do begin
      @(negedge mclk);
      s = busRsp;
      @(posedge mclk);
      if (aw && s.awready) begin
        busReq.awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && s.wready) begin
        busReq.wvalid <= 1'b0;
        w = 1'b0;
      end
    end while (s.bvalid !== 1'b1);
    rs = s.bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    axil_rsp_t s;
    busReq.arvalid <= 1'b1;
    busReq.araddr <= {24'h0, a};
    do begin
      @(negedge mclk);
      s = busRsp;
      @(posedge mclk);
      if (s.arready) begin
        busReq.arvalid <= 1'b0;
      end
    end while (s.rvalid !== 1'b1);
    rv = s.rdata;
    rs = s.rresp;
  endtask

  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask

  // unlock with enable, then write the given value
  task automatic dis(input logic [31:0] v);
    wr(OFS_CTRL, v | 32'h18);
    wr(OFS_CTRL, v);
  endtask

  // count settled cycles until irq or reset request is high
  task automatic waitHigh(input logic useIrq, output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while ((useIrq ? irq : sysResetReq) !== 1'b1);
    @(posedge mclk);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    rdx(OFS_CTRL, 32'h0);
    rdx(OFS_STATUS, 32'h0);
    rdx(OFS_RSTFLAG, 32'h0);
    rd(8'h14);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    wr(8'h14, 32'hFF);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    $display("test reset done");
  endtask

  task automatic t_period();
    int n;
    logic [3:0] c;
    wr(OFS_CTRL, 32'h08);
    for (int i = 0; i < 3; i++) begin
      c = (i == 2) ? 4'h3 : i[3:0];
      wr(OFS_CTRL, 32'h18);
      wr(OFS_CTRL, {26'h0, c[3], 2'b01, c[2:0]});
      waitHigh(1'b0, n);
      waitHigh(1'b0, n);
      chk(n, 8 * (TB << c));
    end
    wr(OFS_CTRL, 32'h18);
    wr(OFS_CTRL, 32'h2A);
    rdx(OFS_CTRL, 32'h29);
    wr(OFS_CTRL, 32'h0B);
    rdx(OFS_CTRL, 32'h29);
    wr(OFS_CTRL, 32'h21);
    rdx(OFS_CTRL, 32'h29);
    $display("test period done");
  endtask

  task automatic t_safety1();
    rdx(OFS_RSTFLAG, 32'h1);
    dis(32'h21);
    rdx(OFS_CTRL, 32'h29);
    wr(OFS_RSTFLAG, 32'h0);
    rdx(OFS_RSTFLAG, 32'h0);
    wr(OFS_CTRL, 32'h39);
    repeat (6) @(posedge mclk);
    wr(OFS_CTRL, 32'h21);
    rdx(OFS_CTRL, 32'h29);
    dis(32'h21);
    rdx(OFS_CTRL, 32'h21);
    $display("test safety level one done");
  endtask

  task automatic t_irq();
    int n;
    wr(OFS_CTRL, 32'h10);
    wr(OFS_CTRL, 32'h00);
    rd(OFS_STATUS);
    chk({31'h0, wdtRunning}, 32'h0);
    wr(OFS_MASK, 32'h1);
    wr(OFS_CTRL, 32'h40);
    chk({31'h0, wdtRunning}, 32'h1);
    waitHigh(1'b1, n);
    wr(OFS_CTRL, 32'h00);
    wr(OFS_MASK, 32'h0);
    @(negedge mclk);
    chk({31'h0, irq}, 32'h0);
    @(posedge mclk);
    rdx(OFS_STATUS, 32'h1);
    rdx(OFS_STATUS, 32'h0);
    wr(OFS_MASK, 32'h3);
    rdx(OFS_MASK, 32'h3);
    wr(OFS_CTRL, 32'h48);
    waitHigh(1'b1, n);
    rdx(OFS_CTRL, 32'h08);
    waitHigh(1'b0, n);
    chk({31'h0, n <= 8 * TB}, 32'h1);
    rdx(OFS_STATUS, 32'h3);
    $display("test interrupt done");
  endtask

  task automatic t_level2();
    int n;
    int p;
    safetyLevel <= SAFETY_L2;
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    rdx(OFS_CTRL, 32'h08);
    dis(32'h00);
    rdx(OFS_CTRL, 32'h08);
    // kicks every three cycles keep the count below the time-out
    waitHigh(1'b0, n);
    wr(OFS_KICK, 32'h0);
    p = rstPulses;
    repeat (12) wr(OFS_KICK, 32'h0);
    chk(rstPulses, p);
    waitHigh(1'b0, n);
    chk({31'h0, n > 8 && n <= 8 * TB}, 32'h1);
    rdx(OFS_KICK, 32'h0);
    $display("test safety level two done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_period();
    t_safety1();
    t_irq();
    t_level2();
    summarize();
  end
endmodule
